/* File: inc/scsdc_pkg.sv */
//Contract
// - with full-rate select clear, the divisor applies as written to the PLL output pre-divided to 200 MHz.
// - with full-rate select set, the extra LSB goes below the divisor field, giving a 7-bit divisor on the 400 MHz PLL output.
// - the extended divisor field sits at bits 28:23, resets to 0x0F and divides the PLL or the oscillator source as bypass selects.
// - the extended divisor is used only while both the legacy use-divider bit and the override bit are set.
// - the extra divisor LSB at bit 22 resets to 1 and counts only while full-rate select is set.
// - the extra divisor LSB changes only on writes that leave full-rate select set.
// - the PLL power-down bit at bit 13 resets to 1; 1 powers the PLL down, 0 lets it run.
// - the bypass bit at bit 11 resets to 1; set takes the oscillator source, clear takes the PLL, both through the divisor.
// - the oscillator source field at bits 6:4 resets to 1 and decodes main, precision, precision/4, 30 kHz and 32.768 kHz; 4 to 6 are reserved.
// - with the override bit 31 set the extended fields replace the legacy ones, otherwise they are ignored.
// - full-rate select at bit 30 picks a 400 MHz or a 200 MHz PLL reference for divisor decoding.
// - each extended field shares the low bit position of the legacy field it replaces, and may be wider.
package scsdc_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int DIV_W  = 7;
  localparam int OSC_W  = 3;
  localparam int SRC_N  = 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_EXT  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_LEG  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STAT = 8'h08;

  // extended register fields
  localparam int EXT_OVR_BIT  = 31;
  localparam int EXT_FULL_BIT = 30;
  localparam int EXT_DIV_HI   = 28;
  localparam int EXT_DIV_LO   = 23;
  localparam int EXT_LSB_BIT  = 22;
  localparam int PD_BIT       = 13;
  localparam int BYP_BIT      = 11;
  localparam int EXT_OSC_HI   = 6;
  localparam int OSC_LO       = 4;

  // legacy register fields, same low bit positions
  localparam int LEG_USEDIV_BIT = 22;
  localparam int LEG_DIV_HI     = 26;
  localparam int LEG_OSC_HI     = 5;

  // status register only
  localparam int STAT_DIVEN_BIT = 31;

  // reserved positions reset to zero, so only live fields are set here
  localparam logic [DATA_W-1:0] EXT_RESET   = 32'h07c0_2810;
  localparam logic [DATA_W-1:0] EXT_RW_MASK = 32'hdf80_2870;
  localparam logic [DATA_W-1:0] LEG_RESET   = 32'h0780_2810;
  localparam logic [DATA_W-1:0] LEG_RW_MASK = 32'h07c0_2830;

  localparam logic [OSC_W-1:0] OSC_MAIN     = 3'h0;
  localparam logic [OSC_W-1:0] OSC_PREC     = 3'h1;
  localparam logic [OSC_W-1:0] OSC_PREC_Q   = 3'h2;
  localparam logic [OSC_W-1:0] OSC_LOW30K   = 3'h3;
  localparam logic [OSC_W-1:0] OSC_EXT32K   = 3'h7;

  typedef struct packed {
    logic                read;
    logic                write;
    logic [ADDR_W-1:0]   address;
    logic [DATA_W-1:0]   writedata;
    logic [DATA_W/8-1:0] byteenable;
  } scsdc_avs_req_s;

  typedef struct packed {
    logic             divide_en;
    logic             full_rate;
    logic [DIV_W-1:0] divisor;
    logic             pll_power_down;
    logic             pll_bypass;
    logic [OSC_W-1:0] osc_source;
  } scsdc_cfg_s;

endpackage : scsdc_pkg

/* File: rtl/scsdc_div.sv */
`timescale 1ns/10ps
module scsdc_div #(
  parameter int DIV_W = 7
) (
  input  wire logic             clk,       // system clock
  input  wire logic             sys_rst,   // sync reset, active high
  input  wire logic             src_tick,  // one pulse per source period
  input  wire logic             div_en,    // divide by divisor+1
  input  wire logic [DIV_W-1:0] divisor,   // divisor code
  output logic                  tick_q     // divided tick
);

  logic [DIV_W-1:0] cnt_q;

  // a divisor change takes effect at once; a count at or above the new divisor wraps on the next source tick
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else if (src_tick) begin
      if (!div_en || cnt_q >= divisor) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= src_tick && (!div_en || cnt_q >= divisor);
    end
  end

endmodule : scsdc_div

/* File: rtl/scsdc_top.sv */
`timescale 1ns/10ps
module scsdc_top
  import scsdc_pkg::*;
(
  input  wire logic                          clk,        // 20 MHz clock
  input  wire logic                          sys_rst,    // sync reset
  input  wire scsdc_pkg::scsdc_avs_req_s     avs_req,    // avalon request
  output logic [scsdc_pkg::DATA_W-1:0]       avs_readdata,    // read data
  output logic                               avs_waitrequest, // stall
  input  wire logic                          pll_tick,   // 400 MHz pll tick
  input  wire logic [scsdc_pkg::SRC_N-1:0]   osc_tick,   // ticks per code
  output scsdc_pkg::scsdc_cfg_s              clk_cfg_q,  // active config
  output logic                               sys_clk_tick // divided tick
);
  import scsdc_pkg::*;

  logic [DATA_W-1:0] ext_q;
  logic [DATA_W-1:0] leg_q;
  logic [OSC_W-1:0]  osc_active_q;
  logic              pll_half_q;
  logic              wait_q;
  logic [DATA_W-1:0] rdata_q;
  scsdc_cfg_s        cfg_d;
  logic              osc_code_ok;
  logic              do_write;
  logic              sel_tick;
  logic [DATA_W-1:0] be_mask;
  logic [DATA_W-1:0] stat_word;

  function automatic logic [DATA_W-1:0] lane_mask(
    input logic [DATA_W/8-1:0] be
  );
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < DATA_W/8; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction : lane_mask

  function automatic logic [DATA_W-1:0] merge(
    input logic [DATA_W-1:0] old_v,
    input logic [DATA_W-1:0] new_v,
    input logic [DATA_W-1:0] mask
  );
    return (old_v & ~mask) | (new_v & mask);
  endfunction : merge

  function automatic logic osc_valid(input logic [OSC_W-1:0] code);
    logic ok;
    case (code)
      OSC_MAIN, OSC_PREC, OSC_PREC_Q, OSC_LOW30K, OSC_EXT32K: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : osc_valid

  // bus handshake: one wait cycle, then the access completes
  assign do_write = avs_req.write && !wait_q;
  assign be_mask  = lane_mask(avs_req.byteenable);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= !((avs_req.read || avs_req.write) && wait_q);
    end
  end

  assign avs_waitrequest = wait_q;

  // extended register, reserved positions never stored
  // reserved ignored
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ext_q <= EXT_RESET;
    end else if (do_write && avs_req.address == OFS_EXT) begin
      ext_q <= merge(ext_q, avs_req.writedata, be_mask & EXT_RW_MASK);
      // lsb write gated
      // written full-rate value is used so both can go in one write
      if (be_mask[EXT_LSB_BIT] && be_mask[EXT_FULL_BIT]
          && avs_req.writedata[EXT_FULL_BIT]) begin
        ext_q[EXT_LSB_BIT] <= avs_req.writedata[EXT_LSB_BIT];
      end else if (be_mask[EXT_LSB_BIT] && !be_mask[EXT_FULL_BIT]
                   && ext_q[EXT_FULL_BIT]) begin
        ext_q[EXT_LSB_BIT] <= avs_req.writedata[EXT_LSB_BIT];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      leg_q <= LEG_RESET;
    end else if (do_write && avs_req.address == OFS_LEG) begin
      leg_q <= merge(leg_q, avs_req.writedata, be_mask & LEG_RW_MASK);
    end
  end

  // effective configuration
  always_comb begin
    cfg_d = '0;
    cfg_d.divide_en = leg_q[LEG_USEDIV_BIT];
    if (ext_q[EXT_OVR_BIT]) begin
      cfg_d.full_rate = ext_q[EXT_FULL_BIT];
      if (ext_q[EXT_FULL_BIT]) begin
        cfg_d.divisor = {ext_q[EXT_DIV_HI:EXT_DIV_LO], ext_q[EXT_LSB_BIT]};
      end else begin
        cfg_d.divisor = {1'b0, ext_q[EXT_DIV_HI:EXT_DIV_LO]};
      end
      cfg_d.pll_power_down = ext_q[PD_BIT];
      cfg_d.pll_bypass = ext_q[BYP_BIT];
      cfg_d.osc_source = ext_q[EXT_OSC_HI:OSC_LO];
    end else begin
      cfg_d.full_rate = 1'b0;
      cfg_d.divisor = {3'h0, leg_q[LEG_DIV_HI:EXT_DIV_LO]};
      cfg_d.pll_power_down = leg_q[PD_BIT];
      cfg_d.pll_bypass = leg_q[BYP_BIT];
      cfg_d.osc_source = {1'b0, leg_q[LEG_OSC_HI:OSC_LO]};
    end
  end

  assign osc_code_ok = osc_valid(cfg_d.osc_source);

  // hold valid source
  // switching on a reserved code would leave the mux on a dead input
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      osc_active_q <= OSC_PREC;
    end else if (osc_code_ok) begin
      osc_active_q <= cfg_d.osc_source;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clk_cfg_q <= '0;
      clk_cfg_q.divisor <= DIV_W'(EXT_RESET[EXT_DIV_HI:EXT_DIV_LO]);
      clk_cfg_q.pll_power_down <= EXT_RESET[PD_BIT];
      clk_cfg_q.pll_bypass <= EXT_RESET[BYP_BIT];
      clk_cfg_q.osc_source <= OSC_PREC;
    end else begin
      clk_cfg_q <= cfg_d;
      clk_cfg_q.osc_source <= osc_code_ok ? cfg_d.osc_source
                                          : osc_active_q;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pll_half_q <= 1'b0;
    end else if (pll_tick) begin
      pll_half_q <= !pll_half_q;
    end
  end

  // no pll ticks while powered down
  always_comb begin
    if (clk_cfg_q.pll_bypass) begin
      sel_tick = osc_tick[clk_cfg_q.osc_source];
    end else if (clk_cfg_q.pll_power_down) begin
      sel_tick = 1'b0;
    end else if (clk_cfg_q.full_rate) begin
      sel_tick = pll_tick;
    end else begin
      sel_tick = pll_tick && pll_half_q;
    end
  end

  scsdc_div #(
    .DIV_W (DIV_W)
  ) u_div (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .src_tick (sel_tick),
    .div_en   (clk_cfg_q.divide_en),
    .divisor  (clk_cfg_q.divisor),
    .tick_q   (sys_clk_tick)
  );

  // status shows what the clock tree really runs on
  always_comb begin
    stat_word = '0;
    stat_word[STAT_DIVEN_BIT] = clk_cfg_q.divide_en;
    stat_word[EXT_FULL_BIT] = clk_cfg_q.full_rate;
    stat_word[EXT_DIV_HI:EXT_LSB_BIT] = clk_cfg_q.divisor;
    stat_word[PD_BIT] = clk_cfg_q.pll_power_down;
    stat_word[BYP_BIT] = clk_cfg_q.pll_bypass;
    stat_word[EXT_OSC_HI:OSC_LO] = clk_cfg_q.osc_source;
  end

  // reserved reads zero
  // read data is loaded in the wait cycle and held until the next read
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_q <= '0;
    end else if (avs_req.read && wait_q) begin
      case (avs_req.address)
        OFS_EXT:  rdata_q <= ext_q;
        OFS_LEG:  rdata_q <= leg_q;
        OFS_STAT: rdata_q <= stat_word;
        default:  rdata_q <= '0;
      endcase
    end
  end

  assign avs_readdata = rdata_q;

endmodule : scsdc_top

/* File: sim/scsdc_top_sva.sv */
`timescale 1ns/10ps
module scsdc_top_sva
  import scsdc_pkg::*;
(
  input logic                      clk,             // clock
  input logic                      sys_rst,         // sync reset
  input scsdc_pkg::scsdc_avs_req_s avs_req,         // bus request
  input logic [31:0]               avs_readdata,    // read data
  input logic                      avs_waitrequest, // stall
  input logic                      pll_tick,        // pll tick
  input logic [7:0]                osc_tick,        // source ticks
  input scsdc_pkg::scsdc_cfg_s     clk_cfg_q,       // active config
  input logic                      sys_clk_tick     // divided tick
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire req = avs_req.read || avs_req.write;

  a_wait_one_cycle: assert property (
    req && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer after one wait cycle");
  a_wait_stands_one: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_reset_cfg_value: assert property (
    $fell(sys_rst) |-> clk_cfg_q == 14'h01f9)
    else $error("config differs from reset value");
  a_pll_down_quiet: assert property (
    (clk_cfg_q.pll_power_down && !clk_cfg_q.pll_bypass)[*2] |=> !sys_clk_tick)
    else $error("tick from a powered down pll");
  a_tick_has_cause: assert property (
    sys_clk_tick |-> $past(pll_tick || (|osc_tick)))
    else $error("tick without a source tick");
  a_divided_gap: assert property (
    sys_clk_tick && clk_cfg_q.divide_en && clk_cfg_q.divisor != 7'h0
    |=> !sys_clk_tick)
    else $error("divided ticks back to back");
  a_osc_code_valid: assert property (
    !(clk_cfg_q.osc_source inside {3'h4, 3'h5, 3'h6}))
    else $error("reserved source code active");
  a_cfg_by_write: assert property ($changed(clk_cfg_q) |->
    $past(avs_req.write) || $past(avs_req.write, 2) || $past(sys_rst))
    else $error("config changed without a write");

  c_write_done: cover property (avs_req.write && !avs_waitrequest);
  c_tick_out: cover property (sys_clk_tick);
  c_full_rate: cover property (clk_cfg_q.full_rate && sys_clk_tick);
endmodule : scsdc_top_sva

bind scsdc_top scsdc_top_sva u_sva (.clk(clk), .sys_rst(sys_rst),
  .avs_req(avs_req), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .pll_tick(pll_tick),
  .osc_tick(osc_tick), .clk_cfg_q(clk_cfg_q), .sys_clk_tick(sys_clk_tick));

/* File: sim/scsdc_top_tb.sv */
`timescale 1ns/10ps
module scsdc_top_tb;
  import scsdc_pkg::*;
  logic           clk, sys_rst, pll_tick, sys_clk_tick, avs_waitrequest;
  logic [31:0]    avs_readdata, q, ext_m, leg_m, wd;
  logic [7:0]     osc_tick;
  logic [2:0]     lo;
  scsdc_avs_req_s avs_req;
  scsdc_cfg_s     clk_cfg_q, ec;
  int             num_errors, tests_run, cnt, i;
  localparam logic [31:0] LEG_W = 32'h0140_2810;
  localparam logic [31:0] LEG_N = 32'h0100_2810;
  localparam logic [31:0] CASES [9] = '{32'h8100_2800, 32'h8100_2810,
    32'h8100_2820, 32'h8100_2830, 32'h8100_2870, 32'hc0c0_0000,
    32'h8080_0000, 32'h8080_2000, 32'h0};

  always #25 clk = ~clk;

  scsdc_top uut (.clk(clk), .sys_rst(sys_rst), .avs_req(avs_req),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pll_tick(pll_tick), .osc_tick(osc_tick), .clk_cfg_q(clk_cfg_q),
    .sys_clk_tick(sys_clk_tick));

  function automatic scsdc_cfg_s exp_cfg(logic [31:0] e, l, logic [2:0] o);
    if (!e[31])
      return {l[22], 1'b0, 3'h0, l[26:23], l[13], l[11], 1'b0, l[5:4]};
    return {l[22], e[30], e[30] ? e[28:22] : {1'b0, e[28:23]}, e[13],
      e[11], (e[6:4] inside {[3'h4:3'h6]}) ? o : e[6:4]};
  endfunction : exp_cfg

  function automatic int exp_cnt(scsdc_cfg_s c, int n);
    if (!c.pll_bypass && c.pll_power_down) return 0;
    if (!c.pll_bypass && !c.full_rate) n = n / 2;
    return c.divide_en ? n / (c.divisor + 1) : n;
  endfunction : exp_cnt

  // status word packs the active config at the extended field positions
  function automatic logic [31:0] exp_stat(scsdc_cfg_s c);
    return {c.divide_en, c.full_rate, 1'b0, c.divisor, 8'h0,
      c.pll_power_down, 1'b0, c.pll_bypass, 4'h0, c.osc_source, 4'h0};
  endfunction : exp_stat

  // extra lsb only follows writes that also set full rate
  function automatic logic [31:0] exp_ext(logic [31:0] o, d);
    return (d & EXT_RW_MASK) | {9'h0, d[30] ? d[22] : o[22], 22'h0};
  endfunction : exp_ext

  task automatic chk(logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH at %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test

  // waitrequest and read data are taken at the rising edge, before that
  // edge's own updates land; the request drops right after that edge
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    int k;
    @(posedge clk);
    avs_req <= {!w, w, a, d, 4'hf};
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (k == 20) begin
      num_errors++;
      stop_test();
    end
    q = avs_readdata;
    avs_req <= '0;
  endtask : bus

  // unused sources stay busy so a wrong selection changes the count
  task automatic ticks(scsdc_cfg_s c, int n);
    int k;
    logic [7:0] s;
    s = 8'h1 << c.osc_source;
    cnt = 0;
    for (k = 0; k < 2 * n + 4; k++) begin
      @(posedge clk);
      if (k >= 2 * n)
        {pll_tick, osc_tick} <= 9'h0;
      else if (c.pll_bypass)
        {pll_tick, osc_tick} <= {1'b1, k[0] ? 8'hff : ~s};
      else
        {pll_tick, osc_tick} <= {k[0], 8'hff};
      @(negedge clk);
      cnt += (sys_clk_tick === 1'b1);
    end
  endtask : ticks

  initial begin
    clk = 0;
    sys_rst = 1;
    avs_req = '0;
    pll_tick = 0;
    osc_tick = '0;
    num_errors = 0;
    tests_run = 0;
    cnt = $urandom(32'h9675);
    repeat (5) @(posedge clk);
    sys_rst <= 0;
    bus(0, OFS_EXT, 0);
    chk(q, EXT_RESET);
    bus(1, 8'h10, '1);
    bus(0, 8'h0c, 0);
    chk(q, 0);
    $display("test reset and unmapped done");
    ext_m = EXT_RESET;
    lo = 3'h1;
    for (i = 0; i < 40; i++) begin
      wd = (i == 0) ? 32'h0 : (i == 1) ? 32'h4000_0000 : $urandom;
      bus(1, OFS_EXT, wd);
      ext_m = exp_ext(ext_m, wd);
      wd = $urandom;
      bus(1, OFS_LEG, wd);
      leg_m = wd & LEG_RW_MASK;
      bus(0, OFS_EXT, 0);
      chk(q, ext_m);
      bus(0, OFS_LEG, 0);
      chk(q, leg_m);
      ec = exp_cfg(ext_m, leg_m, lo);
      chk(clk_cfg_q, ec);
      bus(0, OFS_STAT, 0);
      chk(q, exp_stat(ec));
      lo = ec.osc_source;
    end
    $display("test register writes done");
    for (i = 0; i < 9; i++) begin
      @(posedge clk);
      sys_rst <= 1;
      @(posedge clk);
      sys_rst <= 0;
      bus(1, OFS_EXT, CASES[i]);
      bus(1, OFS_LEG, LEG_N);
      ec = exp_cfg(CASES[i], LEG_N, 3'h1);
      ticks(ec, 4);
      chk(cnt, exp_cnt(ec, 4));
      bus(1, OFS_LEG, LEG_W);
      ec = exp_cfg(CASES[i], LEG_W, 3'h1);
      ticks(ec, 30);
      chk(cnt, exp_cnt(ec, 30));
    end
    $display("test divided ticks done");
    stop_test();
  end
endmodule : scsdc_top_tb
